// [src/exposure_gain_sequencer.sv]
// Purpose: Start, time and align sensor exposure against frame readout.
// Assumes: Timer and software triggers are one-cycle pulses on clk.
// Notes:   The external trigger pin is synchronised before use.
`timescale 1ns/1ps
module exposure_gain_sequencer
    import exposure_seq_pkg::*;
#(
    parameter int unsigned ROWS      = 16,  // Rows read per frame.
    parameter int unsigned ROW_W     = 12,  // Width of the row index.
    parameter int unsigned BLANK_CYC = 4,   // Row blanking length in cycles.
    parameter int unsigned READ_CYC  = 12,  // Row readout length in cycles.
    parameter int unsigned MIN_US    = EXP_MIN_US  // Sensor minimum exposure.
) (
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    // Trigger sources.
    input  wire logic                      timer_trig,
    input  wire logic                      sw_trig,
    input  wire logic                      ext_trig_pin,
    input  wire logic                      trig_enable,
    // Exposure configuration.
    input  wire logic                      exposure_mode,
    input  wire logic                      integration_phase_policy,
    input  wire logic [EXP_W-1:0]          exp_len_us,
    input  wire logic                      row_overlap_en,
    // Gain and offset requests.
    input  wire logic [AGAIN_W-1:0]        analog_gain_req,
    input  wire logic [DGAIN_W-1:0]        digital_gain_req,
    input  wire logic [OFFS_IN_W-1:0]      dark_offset_req,
    // Sensor gain and offset outputs.
    output logic      [AGAIN_W-1:0]        analog_gain_q,
    output logic      [DGAIN_W-1:0]        digital_gain_q,
    output logic      [OFFS_W-1:0]         dark_offset_q,
    // Exposure status and events.
    output logic                           exposing_q,
    output logic                           exp_start_q,
    output logic                           exp_end_q,
    output logic                           invalid_trig_q,
    // Readout status.
    output logic                           readout_q,
    output logic                           frame_start_q,
    output logic                           row_blank_q,
    output logic                           row_read_q,
    output logic      [ROW_W-1:0]          row_idx_q
);

    // =========================================================================
    // Derived readout timing
    // =========================================================================
    // Row time when blanking and readout run side by side.
    localparam int unsigned ROW_OVL_CYC = (BLANK_CYC > READ_CYC) ? BLANK_CYC : READ_CYC;
    localparam int unsigned FRAME_SEQ   = ROWS * (BLANK_CYC + READ_CYC);  // Sequential frame.
    localparam int unsigned FRAME_OVL   = ROWS * ROW_OVL_CYC;             // Overlapped frame.
    localparam int unsigned PH_W        = 16;                             // Phase counter width.

    // =========================================================================
    // Registers
    // =========================================================================
    logic                 ext_meta_q;   // First synchroniser stage, read only by ext_sync_q.
    logic                 ext_sync_q;   // Second synchroniser stage.
    logic                 ext_prev_q;   // Delayed copy for edge detection.
    logic [TICK_W-1:0]    tick_div_q;   // Divides clk down to the microsecond tick.
    logic [TICK_W-1:0]    tick_div_d;
    logic [EXP_W-1:0]     exp_cnt_q;    // Elapsed exposure in microseconds.
    logic [EXP_W-1:0]     exp_cnt_d;
    exp_state_e           ex_q;         // Exposure state.
    exp_state_e           ex_d;
    rd_state_e            rd_q;         // Readout state.
    rd_state_e            rd_d;
    logic [PH_W-1:0]      ph_q;         // Cycle within the current row phase.
    logic [PH_W-1:0]      ph_d;
    logic [ROW_W-1:0]     row_d;
    logic [CNT_W-1:0]     rd_left_q;    // Cycles left in the frame readout.
    logic [CNT_W-1:0]     rd_left_d;

    // =========================================================================
    // Clamping helpers
    // =========================================================================
    // Limits a programmed exposure to the supported range.
    function automatic logic [EXP_W-1:0] clamp_exp(input logic [EXP_W-1:0] v);
        if (v < EXP_W'(MIN_US)) begin
            clamp_exp = EXP_W'(MIN_US);
        end else if (v > EXP_W'(EXP_MAX_US)) begin
            clamp_exp = EXP_W'(EXP_MAX_US);
        end else begin
            clamp_exp = v;
        end
    endfunction : clamp_exp

    // =========================================================================
    // Trigger decode
    // =========================================================================
    wire ext_rise   = ext_sync_q & ~ext_prev_q;                           // Pin rising edge.
    wire trig_any   = timer_trig | sw_trig | (trig_enable & ext_rise);    // [R6]
    wire pulse_mode = (exposure_mode == EXPMODE_PULSE_WIDTH);
    wire sync_mode  = (integration_phase_policy == ALIGN_SYNC);
    wire rd_busy    = (rd_q != RD_IDLE);
    wire rd_fin     = rd_busy & (rd_left_q == CNT_W'(1));                 // Last readout cycle.

    // Programmed exposure in microsecond units and in clock cycles.
    wire [EXP_W-1:0] exp_len  = clamp_exp(exp_len_us);                    // [R10] [R11]
    wire [CNT_W-1:0] exp_cyc  = CNT_W'(exp_len) * CNT_W'(TICK_CYCLES);

    // Synchronous mode takes a trigger whenever no exposure is pending or running.
    wire accept_sync  = sync_mode & (ex_q == EX_IDLE);                   // [R8]
    // Reset mode takes a trigger only when the sensor is fully idle.
    wire accept_reset = ~sync_mode & (ex_q == EX_IDLE) & ~rd_busy;       // [R14]
    wire trig_ok      = trig_any & (accept_sync | accept_reset);
    wire trig_bad     = trig_any & sync_mode & (ex_q != EX_IDLE);        // [R12]
    // One tick of margin: the free-running tick phase can shorten an exposure by up to a tick.
    wire [CNT_W-1:0] pend_lim = exp_cyc + CNT_W'(TICK_CYCLES);            // [R9]
    // Hold a timed start back if the exposure would finish before the readout does.
    wire need_pend    = sync_mode & rd_busy & ~pulse_mode & (rd_left_q > pend_lim);  // [R9]
    wire pend_go      = ~rd_busy | (rd_left_q <= pend_lim);              // [R9]

    // =========================================================================
    // Exposure timing
    // =========================================================================
    wire tick       = (tick_div_q == TICK_W'(TICK_CYCLES - 1));           // [R15]
    wire timed_done = (exp_cnt_q >= exp_len);                             // [R7]
    // The pulse source is relied on to keep its width within limits.
    wire pulse_done = ~ext_sync_q;                                        // [R7] [R16]
    wire exp_done   = pulse_mode ? pulse_done : timed_done;
    // Readout starts at the later of exposure end and previous readout end.
    wire rd_start   = (ex_q == EX_RUN) & exp_done & (~rd_busy | rd_fin);  // [R9] [R13]
    wire ex_start   = (trig_ok & ~need_pend) | ((ex_q == EX_PEND) & pend_go);

    // Tick divider; a reset-mode start restarts the sensor timing.
    assign tick_div_d = ((trig_ok & ~sync_mode) | tick) ? '0 : tick_div_q + TICK_W'(1);  // [R13]

    // Exposure counter clears at each start and saturates at the maximum.
    always_comb begin
        if (ex_start) begin
            exp_cnt_d = '0;                                               // [R15]
        end else if ((ex_q == EX_RUN) & tick & (exp_cnt_q != EXP_W'(EXP_MAX_US))) begin
            exp_cnt_d = exp_cnt_q + EXP_W'(1);                            // [R10] [R15]
        end else begin
            exp_cnt_d = exp_cnt_q;
        end
    end

    // Exposure state transitions.
    always_comb begin
        ex_d = ex_q;
        unique case (ex_q)
            EX_IDLE: begin
                if (trig_ok) begin
                    ex_d = need_pend ? EX_PEND : EX_RUN;                  // [R9] [R13]
                end
            end
            EX_PEND: begin
                if (pend_go) begin
                    ex_d = EX_RUN;                                        // [R9]
                end
            end
            EX_RUN: begin
                if (rd_start) begin
                    ex_d = EX_IDLE;
                end
            end
            default: begin
                ex_d = EX_IDLE;
            end
        endcase
    end

    // =========================================================================
    // Readout sequencing
    // =========================================================================
    wire row_ovl_end = (ph_q == PH_W'(ROW_OVL_CYC - 1));
    wire blank_end   = (ph_q == PH_W'(BLANK_CYC - 1));
    wire read_end    = (ph_q == PH_W'(READ_CYC - 1));
    wire last_row    = (row_idx_q == ROW_W'(ROWS - 1));
    wire row_end     = (rd_q == RD_BOTH) ? row_ovl_end : ((rd_q == RD_READ) & read_end);
    wire [1:0] first_rd = row_overlap_en ? RD_BOTH : RD_BLANK;            // [R4] [R5]

    // Readout state, phase and row advance.
    always_comb begin
        rd_d  = rd_q;
        ph_d  = ph_q + PH_W'(1);
        row_d = row_idx_q;
        unique case (rd_q)
            RD_IDLE: begin
                ph_d = '0;
            end
            RD_BLANK: begin
                if (blank_end) begin
                    rd_d = RD_READ;                                       // [R5]
                    ph_d = '0;
                end
            end
            RD_READ, RD_BOTH: begin
                if (row_end) begin
                    ph_d  = '0;
                    row_d = row_idx_q + ROW_W'(1);
                    rd_d  = (rd_q == RD_BOTH) ? RD_BOTH : RD_BLANK;       // [R4] [R5]
                    if (last_row) begin
                        rd_d = RD_IDLE;
                    end
                end
            end
        endcase
        if (rd_start) begin
            rd_d  = rd_state_e'(first_rd);
            ph_d  = '0;
            row_d = '0;
        end
    end

    // Remaining readout cycles, used to place a delayed exposure start.
    wire [CNT_W-1:0] frame_cyc = row_overlap_en ? CNT_W'(FRAME_OVL) : CNT_W'(FRAME_SEQ); // [R4]
    assign rd_left_d = rd_start ? frame_cyc : (rd_busy ? rd_left_q - CNT_W'(1) : '0);

    // =========================================================================
    // Synchroniser for the external trigger pin
    // =========================================================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_meta_q <= ext_trig_pin;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    // =========================================================================
    // State registers
    // =========================================================================
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_div_q <= '0;
            exp_cnt_q  <= '0;                                             // [R15]
            ex_q       <= EX_IDLE;
            rd_q       <= RD_IDLE;
            ph_q       <= '0;
            row_idx_q  <= '0;
            rd_left_q  <= '0;
        end else begin
            tick_div_q <= tick_div_d;
            exp_cnt_q  <= exp_cnt_d;
            ex_q       <= ex_d;
            rd_q       <= rd_d;
            ph_q       <= ph_d;
            row_idx_q  <= row_d;
            rd_left_q  <= rd_left_d;
        end
    end

    // =========================================================================
    // Status and event outputs
    // =========================================================================
    // Flags and one-cycle events follow the next state so they line up with it.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            exposing_q     <= 1'b0;
            exp_start_q    <= 1'b0;
            exp_end_q      <= 1'b0;
            invalid_trig_q <= 1'b0;
            readout_q      <= 1'b0;
            frame_start_q  <= 1'b0;
            row_blank_q    <= 1'b0;
            row_read_q     <= 1'b0;
        end else begin
            exposing_q     <= (ex_d == EX_RUN);
            exp_start_q    <= ex_start;
            exp_end_q      <= rd_start;                                   // [R9]
            invalid_trig_q <= trig_bad;                                   // [R12]
            readout_q      <= (rd_d != RD_IDLE);
            frame_start_q  <= rd_start;
            // In overlapped rows both phases begin together.
            row_blank_q    <= (rd_d == RD_BLANK) |
                              ((rd_d == RD_BOTH) & (ph_d < PH_W'(BLANK_CYC)));   // [R4] [R5]
            row_read_q     <= (rd_d == RD_READ) |
                              ((rd_d == RD_BOTH) & (ph_d < PH_W'(READ_CYC)));    // [R4] [R5]
        end
    end

    // =========================================================================
    // Gain and dark offset
    // =========================================================================
    // Codes are passed as linear factors: analog in hundredths, digital in tenths.
    wire [OFFS_W-1:0] offs_sat = (dark_offset_req > OFFS_IN_W'(OFFS_MAX)) ?
                                 OFFS_W'(OFFS_MAX) : dark_offset_req[OFFS_W-1:0];   // [R3]

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            analog_gain_q  <= AGAIN_W'(AGAIN_UNITY);
            digital_gain_q <= DGAIN_W'(DGAIN_UNITY);
            dark_offset_q  <= '0;
        end else begin
            analog_gain_q  <= analog_gain_req;                            // [R1]
            digital_gain_q <= digital_gain_req;                           // [R2]
            dark_offset_q  <= offs_sat;                                   // [R3]
        end
    end

endmodule : exposure_gain_sequencer

// [src/exposure_seq_pkg.sv]
// Purpose: Shared constants and types for the exposure and gain sequencer.
// Assumes: Single 10 MHz system clock; synchronous active-high reset.
// Notes:   Timing figures are named once here.
// Operation
// R1 - Analog sensor gain steps of 0.01
// R2 - Digital sensor gain steps of 0.1
// R3 - Dark offset limited to 0 through 255
// R4 - Overlapped mode: blanking parallel with row readout
// R5 - Otherwise blanking then readout, every row
// R6 - Start from timer, enabled pin, or software
// R7 - Timed length programmed; pulse mode follows pulse
// R8 - Synchronous: next exposure overlaps current readout
// R9 - Synchronous: delay start, end at readout end
// R10 - Exposure length resolution is one microsecond
// R11 - Exposure length from sensor minimum to 16 s
// R12 - Synchronous: early trigger dropped, invalid event raised
// R13 - Reset: trigger restarts timing, readout after exposure
// R14 - Reset: triggers during exposure or readout ignored
// R15 - Microsecond tick counter times exposure, reset clears
// R16 - Pulse source holds width within exposure limits
package exposure_seq_pkg;

    // =========================================================================
    // Clock and tick timing
    // =========================================================================
    localparam int unsigned CLK_HZ        = 10_000_000;  // System clock rate in hertz.
    localparam int unsigned TICK_US       = 1;           // Exposure tick period in microseconds.
    localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_US;  // Cycles per tick.
    localparam int unsigned TICK_W        = 4;           // Width of the tick divider.

    // =========================================================================
    // Exposure length limits, in microseconds
    // =========================================================================
    localparam int unsigned EXP_W         = 24;          // Width of exposure length values.
    localparam int unsigned EXP_MAX_SEC   = 16;          // Longest exposure in seconds.
    localparam int unsigned EXP_MAX_US    = EXP_MAX_SEC * 1_000_000;  // Longest in microseconds.
    localparam int unsigned EXP_MIN_US    = 10;          // Sensor minimum, plain default.
    localparam int unsigned CNT_W         = 32;          // Width of cycle-domain comparisons.

    // =========================================================================
    // Gain and offset fields
    // =========================================================================
    localparam int unsigned AGAIN_W       = 12;          // Analog gain code, one step is 0.01.
    localparam int unsigned DGAIN_W       = 8;           // Digital gain code, one step is 0.1.
    localparam int unsigned AGAIN_UNITY   = 100;         // Analog code for a factor of 1.00.
    localparam int unsigned DGAIN_UNITY   = 10;          // Digital code for a factor of 1.0.
    localparam int unsigned OFFS_IN_W     = 10;          // Width of the offset request.
    localparam int unsigned OFFS_W        = 8;           // Width of the applied dark offset.
    localparam int unsigned OFFS_MAX      = 255;         // Highest dark offset in DN.

    // =========================================================================
    // Mode encodings
    // =========================================================================
    typedef enum logic [0:0] {
        ALIGN_SYNC  = 1'b0,   // Readout overlaps the next exposure.
        ALIGN_RESET = 1'b1    // Readout follows the exposure.
    } integration_phase_policy_e;

    typedef enum logic [0:0] {
        EXPMODE_TIMED       = 1'b0,  // Length comes from the programmed value.
        EXPMODE_PULSE_WIDTH = 1'b1   // Length follows the trigger pulse.
    } exposure_mode_e;

    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,  // No exposure pending or running.
        EX_PEND = 2'b01,  // Start held back until the readout tail fits.
        EX_RUN  = 2'b10   // Sensor integrating.
    } exp_state_e;

    typedef enum logic [1:0] {
        RD_IDLE  = 2'b00,  // No frame being read.
        RD_BLANK = 2'b01,  // Row blanking, sequential mode.
        RD_READ  = 2'b10,  // Row readout, sequential mode.
        RD_BOTH  = 2'b11   // Blanking and readout together, overlapped mode.
    } rd_state_e;

endpackage : exposure_seq_pkg

// [dv/exposure_gain_sequencer_props.sv]
// Purpose: Port-level assertions for the exposure and gain sequencer.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ps
module exposure_gain_sequencer_props
    import exposure_seq_pkg::*;
(
    // Inputs of the design.
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic                 sw_trig,
    input wire logic                 integration_phase_policy,
    input wire logic [AGAIN_W-1:0]   analog_gain_req,
    input wire logic [OFFS_IN_W-1:0] dark_offset_req,
    // Outputs of the design.
    input wire logic [AGAIN_W-1:0]   analog_gain_q,
    input wire logic [OFFS_W-1:0]    dark_offset_q,
    input wire logic                 exposing_q,
    input wire logic                 exp_start_q,
    input wire logic                 exp_end_q,
    input wire logic                 invalid_trig_q,
    input wire logic                 readout_q,
    input wire logic                 frame_start_q,
    input wire logic                 row_blank_q,
    input wire logic                 row_read_q
);
    // One clock; checks are off in reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_GAIN_COPY: assert property (
        !$past(sys_rst) |-> analog_gain_q == $past(analog_gain_req))
        else $error("Gain copy wrong.");
    AST_OFFS_SAT: assert property (
        !$past(sys_rst) |-> dark_offset_q ==
        ($past(dark_offset_req) > 10'h0ff ? 8'hff : 8'($past(dark_offset_req))))
        else $error("Offset out of range.");
    AST_START_HOLD: assert property (exp_start_q |-> exposing_q [*8])
        else $error("Exposure too short.");
    AST_RESET_GO: assert property (
        integration_phase_policy == ALIGN_RESET && sw_trig && !exposing_q && !readout_q
        |=> exp_start_q) else $error("Idle trigger lost.");
    AST_RESET_BUSY: assert property (
        exp_start_q && $past(integration_phase_policy) == ALIGN_RESET
        |-> !$past(exposing_q) && !$past(readout_q)) else $error("Busy trigger taken.");
    AST_END_RD: assert property (exp_end_q |-> frame_start_q && readout_q && !exposing_q)
        else $error("End and readout disagree.");
    AST_INVALID: assert property (
        invalid_trig_q |-> $past(integration_phase_policy) == ALIGN_SYNC && !exp_start_q)
        else $error("Bad invalid event.");
    AST_BLANK_FIRST: assert property (
        $rose(row_read_q) && !row_blank_q |-> $past(row_blank_q))
        else $error("Read before blank.");
    AST_ROW_FRAME: assert property (row_blank_q || row_read_q |-> readout_q)
        else $error("Row phase outside frame.");
    // Main scenarios seen at least once.
    CV_SYNC_OVERLAP: cover property (exp_start_q && readout_q);
    CV_INVALID:      cover property (invalid_trig_q);
    CV_ROW_PARALLEL: cover property (row_blank_q && row_read_q);
endmodule : exposure_gain_sequencer_props

// [dv/ext_trigger_model.sv]
// Purpose: External trigger source driving the sequencer trigger pin.
// Assumes: Commands arrive as one-cycle pulses on clk.
// Notes:   The line idles low between pulses.
`timescale 1ns/1ps
module ext_trigger_model (
    // Clock and command.
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [15:0] width,
    // Trigger line.
    output logic             pin
);
    logic [15:0] left_q = 16'h0000;  // Cycles of pulse still to drive.
    // Pulse length is the commanded width, passed through with no clamp to the exposure limits.
    always_ff @(posedge clk) begin
        left_q <= go ? width : (left_q != 16'h0000 ? left_q - 16'h0001 : left_q);
    end
    assign pin = (left_q != 16'h0000);
endmodule : ext_trigger_model

// [dv/exposure_gain_sequencer_bench.sv]
// Purpose: Self-checking bench for the exposure and gain sequencer.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes:   Eight rows keep frames short.
`timescale 1ns/1ps
module exposure_gain_sequencer_bench;
    import exposure_seq_pkg::*;
    localparam int NROWS = 8;                 // Rows per frame.
    localparam int BLK   = 4;                 // Blanking cycles per row.
    localparam int RD    = 12;                // Readout cycles per row.
    localparam int SEQ   = NROWS * (BLK + RD);  // Sequential frame cycles.
    logic clk = 1'b0;
    logic sys_rst, timer_trig, sw_trig, ext_trig_pin, trig_enable, go;
    logic exposure_mode, integration_phase_policy, row_overlap_en;
    logic [EXP_W-1:0]     exp_len_us;
    logic [AGAIN_W-1:0]   analog_gain_req, analog_gain_q;
    logic [DGAIN_W-1:0]   digital_gain_req, digital_gain_q;
    logic [OFFS_IN_W-1:0] dark_offset_req;
    logic [OFFS_W-1:0]    dark_offset_q;
    logic exposing_q, exp_start_q, exp_end_q, invalid_trig_q, readout_q;
    logic frame_start_q, row_blank_q, row_read_q;
    logic [11:0]          row_idx_q;
    int miscompares = 0, checked = 0, cyc = 0, starts = 0, inv_n = 0, rd_n = 0;
    int c_start = 0, c_end = 0;               // Cycles of the last start and end.
    exposure_gain_sequencer #(.ROWS(NROWS), .BLANK_CYC(BLK), .READ_CYC(RD)) DUT (.*);
    ext_trigger_model ext_src (.clk(clk), .go(go), .width(16'd300), .pin(ext_trig_pin));
    initial forever #50 clk = ~clk;
    // Event counters and timeout.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (exp_start_q === 1'b1) begin
            starts <= starts + 1;
            c_start <= cyc;
        end
        if (exp_end_q === 1'b1) c_end <= cyc;
        if (invalid_trig_q === 1'b1) inv_n <= inv_n + 1;
        if (readout_q === 1'b1) rd_n <= rd_n + 1;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    // Range compare; unknowns never match.
    task automatic chk(input logic [31:0] got, input int lo, input int hi);
        checked++;
        if ($isunknown(got) || got < lo || got > hi) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask : chk
    // One-cycle pulse on the timer or the software trigger.
    task automatic trig(input bit tmr);
        @(posedge clk) {timer_trig, sw_trig} <= {tmr, !tmr};
        @(posedge clk) {timer_trig, sw_trig} <= 2'b00;
    endtask : trig
    // One model pin pulse, run to its end.
    task automatic ext_pulse();
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        repeat (310) @(posedge clk);
    endtask : ext_pulse
    // Bounded wait for readout start or idle.
    task automatic wait_for(input bit idle);
        for (int i = 0; i < 4000; i++) begin
            @(negedge clk);
            if (idle ? (i > 8 && exposing_q === 1'b0 && readout_q === 1'b0)
                     : readout_q === 1'b1) break;
        end
    endtask : wait_for
    task automatic t_gain();
        logic [OFFS_IN_W-1:0] offs [4] = '{10'h0ff, 10'h100, 10'h3ff, 10'h000};
        int e;
        @(negedge clk);
        chk(analog_gain_q, AGAIN_UNITY, AGAIN_UNITY);
        chk(digital_gain_q, DGAIN_UNITY, DGAIN_UNITY);
        chk(dark_offset_q, 0, 0);
        foreach (offs[i]) begin
            @(posedge clk) dark_offset_req <= offs[i];
            analog_gain_req <= AGAIN_W'(229 + i);
            digital_gain_req <= DGAIN_W'(15 + i);
            repeat (2) @(negedge clk);
            chk(analog_gain_q, 229 + i, 229 + i);
            chk(digital_gain_q, 15 + i, 15 + i);
            e = offs[i] > OFFS_MAX ? OFFS_MAX : offs[i];
            chk(dark_offset_q, e, e);
        end
        $display("t_gain done");
    endtask : t_gain
    task automatic t_reset(input bit ov);
        int s0, r0;
        @(posedge clk) integration_phase_policy <= ALIGN_RESET;
        row_overlap_en <= ov;
        s0 = starts;
        r0 = rd_n;
        trig(ov);
        repeat (20) @(posedge clk);
        trig(!ov);
        wait_for(1'b0);
        trig(ov);
        wait_for(1'b1);
        chk(starts - s0, 1, 1);
        chk(c_end - c_start, 100, 101);
        chk(rd_n - r0, ov ? NROWS * RD : SEQ, ov ? NROWS * RD : SEQ);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_pulse();
        int s0;
        @(posedge clk) exposure_mode <= EXPMODE_PULSE_WIDTH;
        s0 = starts;
        ext_pulse();
        chk(starts - s0, 0, 0);
        @(posedge clk) trig_enable <= 1'b1;
        ext_pulse();
        wait_for(1'b1);
        chk(starts - s0, 1, 1);
        chk(c_end - c_start, 299, 301);
        @(posedge clk) exposure_mode <= EXPMODE_TIMED;
        trig_enable <= 1'b0;
        $display("t_pulse done");
    endtask : t_pulse
    task automatic t_sync();
        int s0, i0, e1;
        @(posedge clk) integration_phase_policy <= ALIGN_SYNC;
        row_overlap_en <= 1'b0;
        wait_for(1'b1);
        s0 = starts;
        i0 = inv_n;
        trig(1'b0);
        trig(1'b0);
        wait_for(1'b0);
        @(negedge clk);
        e1 = c_end;
        trig(1'b1);
        wait_for(1'b1);
        chk(inv_n - i0, 1, 1);
        chk(starts - s0, 2, 2);
        chk(c_start - e1, 1, SEQ - 1);
        chk(c_end - e1, SEQ, SEQ + 1);
        $display("t_sync done");
    endtask : t_sync
    task automatic final_report();
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial begin
        sys_rst = 1'b1;
        {timer_trig, sw_trig, trig_enable, row_overlap_en, go} = 5'b00000;
        exposure_mode = EXPMODE_TIMED;
        integration_phase_policy = ALIGN_RESET;
        exp_len_us = 24'd10;
        analog_gain_req = AGAIN_W'(AGAIN_UNITY);
        digital_gain_req = DGAIN_W'(DGAIN_UNITY);
        dark_offset_req = 10'h000;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_gain();
        t_reset(1'b0);
        t_reset(1'b1);
        t_pulse();
        t_sync();
        final_report();
    end
endmodule : exposure_gain_sequencer_bench
bind exposure_gain_sequencer exposure_gain_sequencer_props props_i (.*);
